// ==== logic/rx_startup_mode_control.v ====
// Purpose: Digital start-up sequencer and mode decoder of the receiver.
// Assumes: CLK is the buffered reference oscillator, 10 MHz; RSTN async low.
// Notes:   All pin inputs pass two flops before any logic reads them.
`timescale 1ns/1ps
`default_nettype none
`include "rx_startup_regs.vh"

module rx_startup_mode_control #(
    parameter PRECHARGE_CYCLES = `PRECHARGE_CYCLES
) (
    // Clock and reset
    input wire CLK,
    input wire RSTN,
    // Mode pins from the host
    input wire RECEIVER_ENABLE_PIN,
    output wire RX_EN_PULLDOWN_EN,
    input wire AMP_SELECT_PIN_HI,
    input wire AMP_SELECT_PIN_LO,
    output reg AMP_MID_BIAS_EN,
    input wire BAND_SELECT_PIN,
    input wire DEMOD_SELECT_PIN,
    input wire THRESHOLD_MODE_PIN,
    // Events from the analog chain
    input wire OSC_AMP_DETECT,
    input wire SLICER_OUT,
    // Block enables
    output reg BIAS_EN,
    output reg OSC_EN,
    output reg REF_BUF_EN,
    output reg FIRST_AMP_EN,
    output reg SECOND_AMP_EN,
    output reg MIXER_EN,
    output reg IF_EN,
    output reg PLL_EN,
    output reg FSK_DEMOD_EN,
    output reg PRECHARGE_EN,
    // Synthesizer and data path settings
    output reg HIGH_BAND_SEL,
    output reg LO2_FROM_FIRST_DIV,
    output reg [`DIV_W-1:0] FIRST_DIV_RATIO,
    output reg [`DIV_W-1:0] SECOND_DIV_RATIO,
    output reg DEMOD_SWITCH_FSK,
    output reg THRESHOLD_SWITCH_PEAK,
    output reg PEAK_DET_EN,
    // Data output pin
    output reg DATA_OUT_PIN_O,
    output reg DATA_OUT_PIN_OE_N,
    // Open-drain microcontroller clock pin
    input wire MCU_CLOCK_PIN_I,
    output wire MCU_CLOCK_PIN_O,
    output reg MCU_CLOCK_PIN_OE_N,
    // Status
    output reg [`ST_WIDTH-1:0] STARTUP_STATE
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------

    wire [`SYNC_W-1:0] pins_raw;
    wire [`SYNC_W-1:0] pins_s;

    assign pins_raw[`SB_ENABLE] = RECEIVER_ENABLE_PIN;
    assign pins_raw[`SB_AMP_HI] = AMP_SELECT_PIN_HI;
    assign pins_raw[`SB_AMP_LO] = AMP_SELECT_PIN_LO;
    assign pins_raw[`SB_BAND] = BAND_SELECT_PIN;
    assign pins_raw[`SB_DEMOD] = DEMOD_SELECT_PIN;
    assign pins_raw[`SB_THRESH] = THRESHOLD_MODE_PIN;
    assign pins_raw[`SB_OSC_AMP] = OSC_AMP_DETECT;
    assign pins_raw[`SB_SLICER] = SLICER_OUT;
    assign pins_raw[`SB_MCU_PIN] = MCU_CLOCK_PIN_I;

    // The amplitude event is an analog comparator level, so it is
    // synchronised like any pin before the sequencer looks at it.
    pin_sync2 #(
        .WIDTH(`SYNC_W)
    ) u_sync (
        .clk(CLK),
        .rstn(RSTN),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    wire enable_s = pins_s[`SB_ENABLE];
    wire amp_hi_s = pins_s[`SB_AMP_HI];
    wire amp_lo_s = pins_s[`SB_AMP_LO];
    wire band_s = pins_s[`SB_BAND];
    wire demod_s = pins_s[`SB_DEMOD];
    wire thresh_s = pins_s[`SB_THRESH];
    wire osc_amp_s = pins_s[`SB_OSC_AMP];
    wire slicer_s = pins_s[`SB_SLICER];
    wire mcu_pin_s = pins_s[`SB_MCU_PIN];

    // The pull-down is a fixed pad feature and is never released.
    assign RX_EN_PULLDOWN_EN = 1'b1;

    // ------------------------------------------------------------------
    // Enable edge detection
    // ------------------------------------------------------------------

    reg enable_d_r;
    wire enable_rise;

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            enable_d_r <= 1'b0;
        end else begin
            enable_d_r <= enable_s;
        end
    end

    assign enable_rise = enable_s && !enable_d_r;

    // ------------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------------

    localparam [31:0] PRECHARGE_LAST_W = PRECHARGE_CYCLES - 1;
    localparam [`PRECHARGE_CNT_W-1:0] PRECHARGE_LAST = PRECHARGE_LAST_W[`PRECHARGE_CNT_W-1:0];

    reg [`ST_WIDTH-1:0] state_r;
    reg [`ST_WIDTH-1:0] state_nxt;
    reg [`PRECHARGE_CNT_W-1:0] count_r;
    reg [`PRECHARGE_CNT_W-1:0] count_nxt;

    always @* begin
        state_nxt = state_r;
        count_nxt = count_r;
        if (!enable_s) begin
            // Dropping enable wins over every step of the sequence.
            state_nxt = `ST_SHUTDOWN;
            count_nxt = {`PRECHARGE_CNT_W{1'b0}};
        end else begin
            case (state_r)
                `ST_SHUTDOWN: begin
                    if (enable_rise) begin
                        state_nxt = `ST_OSC_START;
                    end
                end
                `ST_OSC_START: begin
                    if (osc_amp_s) begin
                        state_nxt = `ST_PRECHARGE;
                        count_nxt = {`PRECHARGE_CNT_W{1'b0}};
                    end
                end
                `ST_PRECHARGE: begin
                    if (count_r == PRECHARGE_LAST) begin
                        state_nxt = `ST_RECEIVE;
                        count_nxt = {`PRECHARGE_CNT_W{1'b0}};
                    end else begin
                        count_nxt = count_r + {{(`PRECHARGE_CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                `ST_RECEIVE: begin
                    state_nxt = `ST_RECEIVE;
                end
                default: begin
                    state_nxt = `ST_SHUTDOWN;
                    count_nxt = {`PRECHARGE_CNT_W{1'b0}};
                end
            endcase
        end
    end

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= `RST_STATE;
            count_r <= {`PRECHARGE_CNT_W{1'b0}};
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------

    // Selects are decoded continuously; a change while running is taken
    // as is, since the host keeps them steady during operation.
    wire osc_running = (state_nxt != `ST_SHUTDOWN);
    wire chain_up = (state_nxt == `ST_PRECHARGE) || (state_nxt == `ST_RECEIVE);
    wire receiving = (state_nxt == `ST_RECEIVE);
    wire use_first_amp = !amp_hi_s;
    wire use_second_amp = !amp_lo_s;

    // ------------------------------------------------------------------
    // Block enables and settings
    // ------------------------------------------------------------------

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            BIAS_EN <= 1'b0;
            OSC_EN <= 1'b0;
            REF_BUF_EN <= 1'b0;
            FIRST_AMP_EN <= 1'b0;
            SECOND_AMP_EN <= 1'b0;
            MIXER_EN <= 1'b0;
            IF_EN <= 1'b0;
            PLL_EN <= 1'b0;
            FSK_DEMOD_EN <= 1'b0;
            PRECHARGE_EN <= 1'b0;
            AMP_MID_BIAS_EN <= 1'b0;
            LO2_FROM_FIRST_DIV <= 1'b0;
            PEAK_DET_EN <= 1'b0;
            STARTUP_STATE <= `RST_STATE;
        end else begin
            BIAS_EN <= osc_running;
            OSC_EN <= osc_running;
            REF_BUF_EN <= osc_running;
            FIRST_AMP_EN <= chain_up && use_first_amp;
            SECOND_AMP_EN <= chain_up && use_second_amp;
            MIXER_EN <= chain_up;
            IF_EN <= chain_up;
            PLL_EN <= chain_up;
            FSK_DEMOD_EN <= chain_up && demod_s;
            PRECHARGE_EN <= (state_nxt == `ST_PRECHARGE);
            AMP_MID_BIAS_EN <= osc_running;
            LO2_FROM_FIRST_DIV <= chain_up;
            PEAK_DET_EN <= chain_up && thresh_s;
            STARTUP_STATE <= state_nxt;
        end
    end

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            HIGH_BAND_SEL <= 1'b0;
            FIRST_DIV_RATIO <= `FIRST_DIV_LOW_BAND;
            SECOND_DIV_RATIO <= `SECOND_DIV_LOW_BAND;
            DEMOD_SWITCH_FSK <= 1'b0;
            THRESHOLD_SWITCH_PEAK <= 1'b0;
        end else begin
            HIGH_BAND_SEL <= band_s;
            if (band_s) begin
                FIRST_DIV_RATIO <= `FIRST_DIV_HIGH_BAND;
                SECOND_DIV_RATIO <= `SECOND_DIV_HIGH_BAND;
            end else begin
                FIRST_DIV_RATIO <= `FIRST_DIV_LOW_BAND;
                SECOND_DIV_RATIO <= `SECOND_DIV_LOW_BAND;
            end
            DEMOD_SWITCH_FSK <= demod_s;
            THRESHOLD_SWITCH_PEAK <= thresh_s;
        end
    end

    // ------------------------------------------------------------------
    // Data output pin
    // ------------------------------------------------------------------

    // The pin stays released until pre-charge has fully settled, so the
    // host never sees slicer output from uncharged capacitors.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DATA_OUT_PIN_O <= 1'b0;
            DATA_OUT_PIN_OE_N <= 1'b1;
        end else begin
            DATA_OUT_PIN_O <= receiving ? slicer_s : 1'b0;
            DATA_OUT_PIN_OE_N <= !receiving;
        end
    end

    // ------------------------------------------------------------------
    // Microcontroller clock output
    // ------------------------------------------------------------------

    wire div_high;
    wire div_sample;
    reg pullup_seen_r;

    clock_divider_by_eight #(
        .DIVIDE(`MCU_CLK_DIVIDE)
    ) u_clock_divider_by_eight (
        .clk(CLK),
        .rstn(RSTN),
        .run(osc_running),
        .div_high(div_high),
        .sample(div_sample)
    );

    // The pin is released during each high half, so its level at the end
    // of that half tells whether a pull-up exists. A grounded or open pin
    // reads low and keeps the output idle; removal is caught within one
    // divided period.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pullup_seen_r <= 1'b0;
        end else if (!osc_running) begin
            pullup_seen_r <= 1'b0;
        end else if (div_sample) begin
            pullup_seen_r <= mcu_pin_s;
        end
    end

    assign MCU_CLOCK_PIN_O = 1'b0;

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            MCU_CLOCK_PIN_OE_N <= 1'b1;
        end else begin
            MCU_CLOCK_PIN_OE_N <= !(pullup_seen_r && osc_running && !div_high);
        end
    end

endmodule
`default_nettype wire

// ==== logic/rx_startup_regs.vh ====
// Purpose: Shared constants for the receiver start-up and mode controller.
// Assumes: Included by bare name; definitions only.
// Notes:   Counts are in reference clock cycles.
`ifndef RX_STARTUP_REGS_VH
`define RX_STARTUP_REGS_VH

// ----------------------------------------------------------------------
// Start-up sequencer states
// ----------------------------------------------------------------------
`define ST_SHUTDOWN 2'h0
`define ST_OSC_START 2'h1
`define ST_PRECHARGE 2'h2
`define ST_RECEIVE 2'h3
`define ST_WIDTH 2

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define PRECHARGE_CYCLES 5504
`define PRECHARGE_CNT_W 13
`define MCU_CLK_DIVIDE 8

// ----------------------------------------------------------------------
// Synthesizer divider settings per band
// ----------------------------------------------------------------------
`define DIV_W 4
`define FIRST_DIV_LOW_BAND 4'h4
`define SECOND_DIV_LOW_BAND 4'h6
`define FIRST_DIV_HIGH_BAND 4'h2
`define SECOND_DIV_HIGH_BAND 4'hC

// ----------------------------------------------------------------------
// Bit positions of the synchronised pin bundle
// ----------------------------------------------------------------------
`define SYNC_W 9
`define SB_ENABLE 0
`define SB_AMP_HI 1
`define SB_AMP_LO 2
`define SB_BAND 3
`define SB_DEMOD 4
`define SB_THRESH 5
`define SB_OSC_AMP 6
`define SB_SLICER 7
`define SB_MCU_PIN 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_STATE `ST_SHUTDOWN
`define RST_DIV_PHASE 3'h0

`endif

// ==== logic/pin_sync2.v ====
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Each bit is an independent level; no bus coherency is needed.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Levels
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule
`default_nettype wire

// ==== logic/clock_divider_by_eight.v ====
// Purpose: Divides the buffered reference clock for the microcontroller pin.
// Assumes: Run is a level from the same clock domain.
// Notes:   Sample pulses in the last cycle of the released (high) half.
`timescale 1ns/1ps
`default_nettype none
`include "rx_startup_regs.vh"

module clock_divider_by_eight #(
    parameter DIVIDE = `MCU_CLK_DIVIDE
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Control
    input wire run,
    // Divided clock
    output reg div_high,
    output wire sample
);

    reg [2:0] phase_r;
    wire [2:0] phase_nxt;
    localparam [31:0] LAST_W = DIVIDE - 1;
    localparam [31:0] HALF_W = DIVIDE / 2;
    localparam [2:0] LAST = LAST_W[2:0];
    localparam [2:0] HALF = HALF_W[2:0];

    assign phase_nxt = !run ? `RST_DIV_PHASE :
                       (phase_r == LAST) ? 3'h0 : phase_r + 3'h1;
    assign sample = run && (phase_r == HALF - 3'h1);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= `RST_DIV_PHASE;
            div_high <= 1'b1;
        end else begin
            phase_r <= phase_nxt;
            div_high <= (phase_nxt < HALF);
        end
    end

endmodule
`default_nettype wire

// ==== test/rx_startup_monitor.sv ====
// Purpose: Concurrent checks at the ports of the receiver start-up controller.
// Assumes: One clock domain; RSTN asynchronous, active low.
// Notes:   Checks that start from a pin allow for the two-flop input synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "rx_startup_regs.vh"

module rx_startup_monitor #(
    parameter PRECHARGE_CYCLES = `PRECHARGE_CYCLES
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic RECEIVER_ENABLE_PIN,
    input wire logic AMP_SELECT_PIN_HI,
    input wire logic AMP_SELECT_PIN_LO,
    input wire logic BAND_SELECT_PIN,
    input wire logic MCU_CLOCK_PIN_I,
    input wire logic BIAS_EN,
    input wire logic OSC_EN,
    input wire logic FIRST_AMP_EN,
    input wire logic SECOND_AMP_EN,
    input wire logic MIXER_EN,
    input wire logic PLL_EN,
    input wire logic FSK_DEMOD_EN,
    input wire logic PRECHARGE_EN,
    input wire logic HIGH_BAND_SEL,
    input wire logic [`DIV_W-1:0] FIRST_DIV_RATIO,
    input wire logic [`DIV_W-1:0] SECOND_DIV_RATIO,
    input wire logic DEMOD_SWITCH_FSK,
    input wire logic DATA_OUT_PIN_OE_N,
    input wire logic MCU_CLOCK_PIN_O,
    input wire logic MCU_CLOCK_PIN_OE_N,
    input wire logic [`ST_WIDTH-1:0] STARTUP_STATE
);
    // ------------------------------------------------------------
    // Cycles spent with pre-charge active
    // ------------------------------------------------------------
    logic [15:0] pc_cnt_r;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pc_cnt_r <= 16'h0000;
        end else begin
            pc_cnt_r <= PRECHARGE_EN ? pc_cnt_r + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    property p_start;
        $rose(RECEIVER_ENABLE_PIN) && STARTUP_STATE == 2'h0 |-> ##[1:4] STARTUP_STATE == 2'h1;
    endproperty
    a_start: assert property (p_start) else $error("start-up did not begin");
    property p_osc_first;
        STARTUP_STATE == 2'h1 |-> BIAS_EN && OSC_EN && !FIRST_AMP_EN && !SECOND_AMP_EN && !MIXER_EN
            && !PLL_EN && !PRECHARGE_EN && DATA_OUT_PIN_OE_N;
    endproperty
    a_osc_first: assert property (p_osc_first) else $error("extra blocks enabled early");
    property p_chain;
        PRECHARGE_EN |-> STARTUP_STATE == 2'h2 && MIXER_EN && PLL_EN && BIAS_EN;
    endproperty
    a_chain: assert property (p_chain) else $error("pre-charge without full chain");
    property p_precharge_len;
        $fell(PRECHARGE_EN) && STARTUP_STATE == 2'h3 |-> pc_cnt_r == PRECHARGE_CYCLES;
    endproperty
    a_precharge_len: assert property (p_precharge_len) else $error("pre-charge length wrong");
    property p_data_oe;
        !DATA_OUT_PIN_OE_N |-> STARTUP_STATE == 2'h3 && !PRECHARGE_EN;
    endproperty
    a_data_oe: assert property (p_data_oe) else $error("data output driven too early");
    property p_abort;
        $fell(RECEIVER_ENABLE_PIN) |-> ##[1:4] (STARTUP_STATE == 2'h0 && !PRECHARGE_EN && DATA_OUT_PIN_OE_N);
    endproperty
    a_abort: assert property (p_abort) else $error("shutdown not reached");
    property p_band;
        $stable(BAND_SELECT_PIN)[*5] |-> HIGH_BAND_SEL == BAND_SELECT_PIN
            && FIRST_DIV_RATIO == (BAND_SELECT_PIN ? 4'h2 : 4'h4)
            && SECOND_DIV_RATIO == (BAND_SELECT_PIN ? 4'hC : 4'h6);
    endproperty
    a_band: assert property (p_band) else $error("divider ratios do not match band");
    property p_amp;
        (STARTUP_STATE == 2'h3 && $stable({AMP_SELECT_PIN_HI, AMP_SELECT_PIN_LO}))[*4]
            |-> FIRST_AMP_EN == !AMP_SELECT_PIN_HI && SECOND_AMP_EN == !AMP_SELECT_PIN_LO;
    endproperty
    a_amp: assert property (p_amp) else $error("amplifier decode wrong");
    property p_demod;
        FSK_DEMOD_EN |-> DEMOD_SWITCH_FSK && STARTUP_STATE[1];
    endproperty
    a_demod: assert property (p_demod) else $error("frequency demodulator enabled in amplitude mode");
    property p_mcu_half;
        @(posedge CLK) disable iff (!RSTN || !RECEIVER_ENABLE_PIN)
        $fell(MCU_CLOCK_PIN_OE_N) |-> (!MCU_CLOCK_PIN_OE_N && !MCU_CLOCK_PIN_O)[*4] ##1 MCU_CLOCK_PIN_OE_N[*4];
    endproperty
    a_mcu_half: assert property (p_mcu_half) else $error("clock output period wrong");
    property p_mcu_ground;
        (!MCU_CLOCK_PIN_I)[*8] |-> MCU_CLOCK_PIN_OE_N;
    endproperty
    a_mcu_ground: assert property (p_mcu_ground) else $error("clock output driven without pull-up");

    c_receive: cover property (STARTUP_STATE == 2'h2 ##1 STARTUP_STATE == 2'h3);
    c_mcu_drive: cover property ($fell(MCU_CLOCK_PIN_OE_N));
    c_abort: cover property (PRECHARGE_EN ##1 STARTUP_STATE == 2'h0);
    c_high_band: cover property (HIGH_BAND_SEL && STARTUP_STATE == 2'h3);
endmodule

bind rx_startup_mode_control rx_startup_monitor #(.PRECHARGE_CYCLES(PRECHARGE_CYCLES)) mon (.*);
`default_nettype wire

// ==== test/rx_far_side_model.sv ====
// Purpose: Analog chain and board around the controller: oscillator, pull-up, data line.
// Assumes: Driven from the bench clock; the amplitude detect changes at the falling edge, the pin levels follow the controller outputs.
// Notes:   A released data line shows the inverse of its last value, never a stale copy.
`timescale 1ns/1ps
`default_nettype none

module rx_far_side_model (
    input wire logic CLK,
    input wire logic pullup_fitted,
    input wire logic [7:0] osc_build,
    input wire logic OSC_EN,
    input wire logic MCU_CLOCK_PIN_O,
    input wire logic MCU_CLOCK_PIN_OE_N,
    input wire logic DATA_OUT_PIN_O,
    input wire logic DATA_OUT_PIN_OE_N,
    output var logic OSC_AMP_DETECT,
    output wire logic MCU_CLOCK_PIN_I,
    output wire logic data_line
);
    logic [7:0] amp_cnt = 8'h00;
    logic last_data = 1'b0;
    initial OSC_AMP_DETECT = 1'b0;
    // Amplitude builds from noise only while the oscillator is enabled.
    always @(negedge CLK) begin
        amp_cnt <= !OSC_EN ? 8'h00 : (amp_cnt == 8'hFF) ? amp_cnt : amp_cnt + 8'h01;
        OSC_AMP_DETECT <= OSC_EN && amp_cnt >= osc_build;
    end
    always @(posedge CLK) begin
        if (!DATA_OUT_PIN_OE_N) begin
            last_data <= DATA_OUT_PIN_O;
        end
    end
    assign data_line = DATA_OUT_PIN_OE_N ? ~last_data : DATA_OUT_PIN_O;
    // A grounded or open clock pin reads low whatever the controller does.
    assign MCU_CLOCK_PIN_I = pullup_fitted ? (MCU_CLOCK_PIN_OE_N ? 1'b1 : MCU_CLOCK_PIN_O) : 1'b0;
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the receiver start-up and mode controller.
// Assumes: Pre-charge shortened to 20 cycles; inputs change at the falling edge.
// Notes:   Select pins change only in shutdown, as a host must keep them.
`timescale 1ns/1ps
`default_nettype none
`include "rx_startup_regs.vh"

module tb;
    localparam int PCYC = 20;
    logic CLK, RSTN, RECEIVER_ENABLE_PIN, AMP_SELECT_PIN_HI, AMP_SELECT_PIN_LO, BAND_SELECT_PIN;
    logic DEMOD_SELECT_PIN, THRESHOLD_MODE_PIN, SLICER_OUT, pullup_fitted;
    logic [7:0] osc_build;
    wire RX_EN_PULLDOWN_EN, AMP_MID_BIAS_EN, OSC_AMP_DETECT, MCU_CLOCK_PIN_I, data_line, REF_BUF_EN;
    wire BIAS_EN, OSC_EN, FIRST_AMP_EN, SECOND_AMP_EN, MIXER_EN, IF_EN, PLL_EN, FSK_DEMOD_EN;
    wire PRECHARGE_EN, HIGH_BAND_SEL, LO2_FROM_FIRST_DIV, DEMOD_SWITCH_FSK, THRESHOLD_SWITCH_PEAK, PEAK_DET_EN;
    wire DATA_OUT_PIN_O, DATA_OUT_PIN_OE_N, MCU_CLOCK_PIN_O, MCU_CLOCK_PIN_OE_N;
    wire [`DIV_W-1:0] FIRST_DIV_RATIO, SECOND_DIV_RATIO;
    wire [`ST_WIDTH-1:0] STARTUP_STATE;
    int fails = 0;
    int tests_run = 0;
    logic exp_q[$];

    rx_startup_mode_control #(.PRECHARGE_CYCLES(PCYC)) dut (.*);
    rx_far_side_model model (.*);

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wait_state(input logic [1:0] s, output int n);
        n = 0;
        while (STARTUP_STATE !== s) begin
            @(negedge CLK);
            n++;
            if (n > 500) begin
                fails++;
                final_report;
            end
        end
    endtask

    // Runs one start-up; a non-negative abort_at drops the enable mid pre-charge.
    task automatic start_rx(input int abort_at);
        int n;
        RECEIVER_ENABLE_PIN = 1'b1;
        wait_state(2'h1, n);
        chk(n, 3);
        chk({BIAS_EN, OSC_EN, REF_BUF_EN, AMP_MID_BIAS_EN, FIRST_AMP_EN, SECOND_AMP_EN, MIXER_EN, PLL_EN,
            PRECHARGE_EN}, 9'h1E0);
        wait_state(2'h2, n);
        chk({MIXER_EN, IF_EN, PLL_EN, LO2_FROM_FIRST_DIV, PRECHARGE_EN, DATA_OUT_PIN_OE_N}, 6'h3F);
        n = 0;
        while (STARTUP_STATE === 2'h2 && n != abort_at) begin
            @(negedge CLK);
            n++;
        end
        if (abort_at >= 0) begin
            RECEIVER_ENABLE_PIN = 1'b0;
            wait_state(2'h0, n);
            chk({PRECHARGE_EN, MIXER_EN, DATA_OUT_PIN_OE_N}, 3'h1);
        end else begin
            chk(n, PCYC);
            chk({STARTUP_STATE, DATA_OUT_PIN_OE_N, PRECHARGE_EN}, 4'hC);
        end
    endtask

    initial begin
        int n, amp, band, fb, sb;
        RSTN = 1'b0;
        RECEIVER_ENABLE_PIN = 1'b1;
        {AMP_SELECT_PIN_HI, AMP_SELECT_PIN_LO, BAND_SELECT_PIN, DEMOD_SELECT_PIN} = 4'h0;
        {THRESHOLD_MODE_PIN, SLICER_OUT, pullup_fitted} = 3'h0;
        osc_build = 8'h05;
        void'($urandom(32'h4ba0586b));
        repeat (6) @(negedge CLK);
        chk({STARTUP_STATE, BIAS_EN, PRECHARGE_EN, DATA_OUT_PIN_OE_N, MCU_CLOCK_PIN_OE_N, FIRST_DIV_RATIO,
            SECOND_DIV_RATIO}, 16'h0346);
        chk(RX_EN_PULLDOWN_EN, 1);
        RSTN = 1'b1;
        // The synchroniser leaves reset low, so a pin already high at release counts as an enable edge.
        repeat (6) @(negedge CLK);
        chk(STARTUP_STATE, 1);
        RECEIVER_ENABLE_PIN = 1'b0;
        repeat (4) @(negedge CLK);
        for (int i = 0; i < 6; i++) begin
            band = $urandom % 2;
            amp = i % 3;
            BAND_SELECT_PIN = band[0];
            AMP_SELECT_PIN_LO = (amp == 0);
            AMP_SELECT_PIN_HI = (amp == 1);
            DEMOD_SELECT_PIN = $urandom;
            THRESHOLD_MODE_PIN = $urandom;
            pullup_fitted = i[0];
            osc_build = $urandom % 40;
            if (i == 4) begin
                start_rx(PCYC / 2);
                repeat (4) @(negedge CLK);
            end
            start_rx(-1);
            fb = band ? 2 : 4;
            sb = 24 / fb;
            chk({FIRST_DIV_RATIO, SECOND_DIV_RATIO, HIGH_BAND_SEL}, {fb[3:0], sb[3:0], band[0]});
            chk({FIRST_AMP_EN, SECOND_AMP_EN}, {amp != 1, amp != 0});
            chk({FSK_DEMOD_EN, DEMOD_SWITCH_FSK}, {2{DEMOD_SELECT_PIN}});
            chk({PEAK_DET_EN, THRESHOLD_SWITCH_PEAK}, {2{THRESHOLD_MODE_PIN}});
            for (int k = 0; k < 4; k++) begin
                SLICER_OUT = $urandom;
                exp_q.push_back(SLICER_OUT);
                repeat (4) @(negedge CLK);
                chk(data_line, exp_q.pop_front());
            end
            n = 0;
            repeat (16) begin
                @(negedge CLK);
                n += !MCU_CLOCK_PIN_OE_N;
            end
            chk(n, pullup_fitted ? 8 : 0);
            RECEIVER_ENABLE_PIN = 1'b0;
            wait_state(2'h0, n);
            chk(n, 3);
            repeat (2) @(negedge CLK);
            chk({DATA_OUT_PIN_OE_N, MCU_CLOCK_PIN_OE_N, BIAS_EN, OSC_EN, FIRST_AMP_EN, SECOND_AMP_EN}, 6'h30);
        end
        final_report;
    end
endmodule
`default_nettype wire
